// ---- include/utc_report_defs.svh ----
// Purpose: offsets, field positions, reset values and counts of the UTC report framer
// Assumes: 32-bit AHB-Lite register word per offset
// Notes: definitions only
`ifndef UTC_REPORT_DEFS_SVH
`define UTC_REPORT_DEFS_SVH

`define REG_CTRL 8'h00
`define REG_TRACK 8'h04
`define REG_TIME 8'h08
`define REG_DATE 8'h0C
`define REG_EVCNT 8'h10
`define REG_FLAGS 8'h14
`define REG_IRQ_STAT 8'h18
`define REG_IRQ_CLR 8'h1C
`define REG_IRQ_EN 8'h20

`define CTRL_ENABLE 0
`define CTRL_EVENT_EN 1
`define CTRL_UTC_VALID 2
`define CTRL_LEAP_SCHED 3
`define CTRL_LEAP_PEND 4
`define CTRL_LEAP_WARN 5
`define CTRL_WIDTH 6
`define CTRL_RESET 6'h03

`define IRQ_SENT 0
`define IRQ_LEAP_START 1
`define IRQ_OVERRUN 2
`define IRQ_WIDTH 3

`define FLAG_UTC_VALID 0
`define FLAG_SCHED 4
`define FLAG_PEND 5
`define FLAG_WARN 6
`define FLAG_PROG 7

`define REPORT_SUBCODE 8'hAD
`define REPORT_FILL 8'hFF
`define REPORT_BYTES 5'd22
`define REPORT_LAST 5'd21
`define SYNC_GROUP_MAX 3'd4
`define SYNC_FOLLOWERS 3'd3
`define LEAP_SECOND 8'd60
`define YEAR_RESET 16'h07D0
`define TRACK_RESET 8'h03
`endif

// ---- include/utc_report_pkg.sv ----
// Purpose: types shared by the UTC report framer and its bench
// Assumes: constants live in utc_report_defs.svh
// Notes: types only
package utc_report_pkg;
	typedef enum logic {IDLE, SEND} frame_state_t;

	typedef enum logic [7:0] {
		navigating, single_satellite_timing, approximate_time, awaiting_time_startup,
		awaiting_init_startup, precision_dilution_excessive, chosen_satellite_unusable,
		zero_satellites_usable, one_satellite_usable, two_satellites_usable,
		three_satellites_usable, invalid_solution, differential_corrections,
		overdetermined_fixes
	} track_status_t;

	typedef struct packed {
		logic valid;
		logic first;
		logic last;
		logic [7:0] data;
	} byte_stream_t;

	typedef struct packed {
		logic [7:0] hour;
		logic [7:0] minute;
		logic [7:0] second;
		logic [7:0] day;
		logic [7:0] month;
		logic [15:0] year;
	} calendar_t;
endpackage

// ---- src/utc_time_report_framer.sv ----
// Purpose: builds the UTC time report on each PPS edge and on external events
// Assumes: frac_second comes from the on-chip timebase on mclk; pins are synchronised here
// Notes: calendar, leap flags and report stream kept here; host config via AHB-Lite
//
// What this block does
// - A report goes out on each PPS edge and, when enabled, on each external event unless an earlier event report still waits.
// - This report leads the group of at most four synchronous reports of a second.
// - The host can disable the report and change its configuration.
// - Bytes 1-2 hold the 16-bit event counter, zero for a PPS report.
// - Bytes 3-10 hold the double giving time elapsed in the current second.
// - Hour, minute, second (60 only in a leap second), day, month, 16-bit year follow.
// - Byte 18 carries the tracking-status code.
// - Codes 0 to 6 mean navigating, one-satellite, approximate, two start-ups, high DOP, bad sat.
// - Codes 7 to 13 mean zero to three sats, invalid, differential, overdetermined.
// - Byte 19 is the leap flag byte with bit 0 for UTC valid and bits 1-3 reserved.
// - Bit 4 shows a scheduled leap second until its date is past.
// - Bit 5 warns of a leap second at the end of the day and clears as the leap second starts.
// - Bit 6 shows the leap exception window of six hours each side of the leap.
// - On a leap day the date rolls over one second late, after the leap second.
`timescale 1ns/100ps
`include "utc_report_defs.svh"

module utc_time_report_framer (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic pps_pin,
	input wire logic event_pin,
	input wire logic [63:0] frac_second,
	output utc_report_pkg::byte_stream_t tx,
	input wire logic tx_ready,
	output logic [2:0] followers_go,
	output logic irq
);
	import utc_report_pkg::*;

	// Pin synchronisers; stage 1 is read only by stage 2
	logic pps_s1_q, pps_s2_q, pps_s3_q;
	logic evt_s1_q, evt_s2_q, evt_s3_q;
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			{pps_s1_q, pps_s2_q, pps_s3_q} <= 3'h0;
			{evt_s1_q, evt_s2_q, evt_s3_q} <= 3'h0;
		end else begin
			{pps_s1_q, pps_s2_q, pps_s3_q} <= {pps_pin, pps_s1_q, pps_s2_q};
			{evt_s1_q, evt_s2_q, evt_s3_q} <= {event_pin, evt_s1_q, evt_s2_q};
		end
	end
	wire pps_tick = pps_s2_q & ~pps_s3_q;
	wire evt_tick = evt_s2_q & ~evt_s3_q;

	// AHB-Lite slave: zero wait state, always OKAY
	logic wr_pend_q;
	logic [7:0] wr_addr_q;
	wire addr_ok = hsel & hready & htrans[1];
	wire rd_take = addr_ok & ~hwrite;
	wire wr_take = addr_ok & hwrite;
	wire [7:0] rd_addr = haddr[7:0];

	logic [`CTRL_WIDTH-1:0] ctrl_q;
	track_status_t track_q;
	calendar_t cal_q;
	logic leap_prog_q;
	logic [15:0] evcnt_q;
	logic [`IRQ_WIDTH-1:0] irq_stat_q, irq_en_q;

	wire wr_ctrl = wr_pend_q && (wr_addr_q == `REG_CTRL);
	wire wr_track = wr_pend_q && (wr_addr_q == `REG_TRACK);
	wire wr_time = wr_pend_q && (wr_addr_q == `REG_TIME);
	wire wr_date = wr_pend_q && (wr_addr_q == `REG_DATE);
	wire wr_clr = wr_pend_q && (wr_addr_q == `REG_IRQ_CLR);
	wire wr_en = wr_pend_q && (wr_addr_q == `REG_IRQ_EN);

	wire [7:0] flag_byte = {leap_prog_q, ctrl_q[`CTRL_LEAP_WARN], ctrl_q[`CTRL_LEAP_PEND],
		ctrl_q[`CTRL_LEAP_SCHED], 3'h0, ctrl_q[`CTRL_UTC_VALID]};

	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (rd_addr == `REG_CTRL) begin
			rd_mux = {26'h0, ctrl_q};
		end else if (rd_addr == `REG_TRACK) begin
			rd_mux = {24'h0, track_q};
		end else if (rd_addr == `REG_TIME) begin
			rd_mux = {8'h0, cal_q.hour, cal_q.minute, cal_q.second};
		end else if (rd_addr == `REG_DATE) begin
			rd_mux = {cal_q.year, cal_q.month, cal_q.day};
		end else if (rd_addr == `REG_EVCNT) begin
			rd_mux = {16'h0, evcnt_q};
		end else if (rd_addr == `REG_FLAGS) begin
			rd_mux = {24'h0, flag_byte};
		end else if (rd_addr == `REG_IRQ_STAT) begin
			rd_mux = {29'h0, irq_stat_q};
		end else if (rd_addr == `REG_IRQ_EN) begin
			rd_mux = {29'h0, irq_en_q};
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			wr_pend_q <= wr_take;
			wr_addr_q <= haddr[7:0];
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (rd_take) begin
				hrdata <= rd_mux;
			end
		end
	end

	// Calendar: days in month, Gregorian leap years
	function automatic logic [7:0] month_days(input logic [7:0] m, input logic [15:0] y);
		logic leap_yr;
		leap_yr = (y[1:0] == 2'b00) && (((y % 16'd100) != 16'h0000) || ((y % 16'd400) == 16'h0000));
		case (m)
			8'd2: month_days = leap_yr ? 8'd29 : 8'd28;
			8'd4, 8'd6, 8'd9, 8'd11: month_days = 8'd30;
			default: month_days = 8'd31;
		endcase
	endfunction

	// Next calendar on a second tick
	wire end_of_day = (cal_q.hour == 8'd23) && (cal_q.minute == 8'd59) && (cal_q.second == 8'd59);
	wire in_leap_sec = (cal_q.second == `LEAP_SECOND);
	wire leap_start = pps_tick && end_of_day && ctrl_q[`CTRL_LEAP_PEND];
	calendar_t cal_next;
	always_comb begin
		cal_next = cal_q;
		if (leap_start) begin
			cal_next.second = `LEAP_SECOND;
		end else if (in_leap_sec || end_of_day) begin
			// Date rolls after 23:59:59, or after second 60 on a leap day
			cal_next.hour = 8'd0;
			cal_next.minute = 8'd0;
			cal_next.second = 8'd0;
			if (cal_q.day >= month_days(cal_q.month, cal_q.year)) begin
				cal_next.day = 8'd1;
				if (cal_q.month >= 8'd12) begin
					cal_next.month = 8'd1;
					cal_next.year = cal_q.year + 16'd1;
				end else begin
					cal_next.month = cal_q.month + 8'd1;
				end
			end else begin
				cal_next.day = cal_q.day + 8'd1;
			end
		end else if (cal_q.second >= 8'd59) begin
			cal_next.second = 8'd0;
			if (cal_q.minute >= 8'd59) begin
				cal_next.minute = 8'd0;
				cal_next.hour = cal_q.hour + 8'd1;
			end else begin
				cal_next.minute = cal_q.minute + 8'd1;
			end
		end else begin
			cal_next.second = cal_q.second + 8'd1;
		end
	end

	// Control bits: software writes, hardware retires pending and scheduled flags
	logic [`CTRL_WIDTH-1:0] ctrl_d;
	always_comb begin
		ctrl_d = wr_ctrl ? hwdata[`CTRL_WIDTH-1:0] : ctrl_q;
		if (leap_start) begin
			ctrl_d[`CTRL_LEAP_PEND] = 1'b0;
		end
		if (pps_tick && in_leap_sec) begin
			ctrl_d[`CTRL_LEAP_SCHED] = 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ctrl_q <= `CTRL_RESET;
			track_q <= track_status_t'(`TRACK_RESET);
			cal_q <= '{8'd0, 8'd0, 8'd0, 8'd1, 8'd1, `YEAR_RESET};
			leap_prog_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			if (wr_track) begin
				track_q <= track_status_t'(hwdata[7:0]);
			end
			if (wr_time) begin
				{cal_q.hour, cal_q.minute, cal_q.second} <= hwdata[23:0];
			end else if (pps_tick) begin
				{cal_q.hour, cal_q.minute, cal_q.second} <=
					{cal_next.hour, cal_next.minute, cal_next.second};
			end
			if (wr_date) begin
				{cal_q.year, cal_q.month, cal_q.day} <= hwdata;
			end else if (pps_tick) begin
				{cal_q.year, cal_q.month, cal_q.day} <= {cal_next.year, cal_next.month, cal_next.day};
			end
			if (leap_start) begin
				leap_prog_q <= 1'b1;
			end else if (pps_tick) begin
				leap_prog_q <= 1'b0;
			end
		end
	end

	// Trigger capture; a PPS report samples the calendar at the earliest two cycles after the tick
	logic pps_seen_q, pps_pend_q, evt_pend_q;
	logic [15:0] evt_stamp_q;
	logic [63:0] evt_frac_q;
	frame_state_t state_q;
	logic [4:0] idx_q;
	logic [175:0] snap_q;
	logic [2:0] followers_q;
	wire enabled = ctrl_q[`CTRL_ENABLE];
	wire evt_ok = evt_tick && enabled && ctrl_q[`CTRL_EVENT_EN];
	wire start_send = (state_q == IDLE) && (pps_pend_q || evt_pend_q);
	wire pick_pps = pps_pend_q; // PPS report leads the second
	wire out_free = ~tx.valid | tx_ready;
	wire done_byte = (state_q == SEND) && out_free;
	wire finish = done_byte && (idx_q == `REPORT_LAST);
	wire overrun = evt_ok && evt_pend_q && !(start_send && !pick_pps);

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			pps_seen_q <= 1'b0;
			pps_pend_q <= 1'b0;
			evt_pend_q <= 1'b0;
			evcnt_q <= 16'h0000;
			evt_stamp_q <= 16'h0000;
			evt_frac_q <= 64'h0000_0000_0000_0000;
		end else begin
			pps_seen_q <= pps_tick && enabled;
			if (pps_seen_q) begin
				pps_pend_q <= 1'b1;
			end else if (start_send && pick_pps) begin
				pps_pend_q <= 1'b0;
			end
			if (evt_ok) begin
				evcnt_q <= evcnt_q + 16'd1;
				if (!evt_pend_q || (start_send && !pick_pps)) begin
					evt_pend_q <= 1'b1;
					evt_stamp_q <= evcnt_q + 16'd1;
					evt_frac_q <= frac_second;
				end
			end else if (start_send && !pick_pps) begin
				evt_pend_q <= 1'b0;
			end
		end
	end

	// Snapshot: byte 0 in the top lane, each field MSB first
	wire [15:0] snap_count = pick_pps ? 16'h0000 : evt_stamp_q;
	wire [63:0] snap_frac = pick_pps ? 64'h0000_0000_0000_0000 : evt_frac_q;
	wire [175:0] snap_d = {`REPORT_SUBCODE, snap_count, snap_frac,
		cal_q.hour, cal_q.minute, cal_q.second, cal_q.day, cal_q.month, cal_q.year,
		track_q, flag_byte, `REPORT_FILL, `REPORT_FILL};

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_q <= IDLE;
			idx_q <= 5'd0;
			snap_q <= '0;
			tx <= '0;
			followers_q <= 3'd0;
			followers_go <= 3'd0;
		end else begin
			followers_go <= 3'd0;
			if (out_free) begin
				tx.valid <= 1'b0;
			end
			case (state_q)
				IDLE: begin
					if (start_send) begin
						state_q <= SEND;
						idx_q <= 5'd0;
						snap_q <= snap_d;
						followers_q <= pick_pps ? `SYNC_FOLLOWERS : 3'd0;
					end
				end
				SEND: begin
					if (out_free) begin
						tx.valid <= 1'b1;
						tx.first <= (idx_q == 5'd0);
						tx.last <= (idx_q == `REPORT_LAST);
						tx.data <= snap_q[175:168];
						snap_q <= {snap_q[167:0], 8'h00};
						idx_q <= idx_q + 5'd1;
						if (idx_q == `REPORT_LAST) begin
							state_q <= IDLE;
							// Other synchronous reports may follow only after this one
							followers_go <= followers_q;
						end
					end
				end
				default: state_q <= IDLE;
			endcase
		end
	end

	// Interrupts: set wins over a clear in the same cycle
	wire [`IRQ_WIDTH-1:0] irq_set = {overrun, leap_start, finish};
	wire [`IRQ_WIDTH-1:0] irq_clr = wr_clr ? hwdata[`IRQ_WIDTH-1:0] : '0;
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			irq_stat_q <= '0;
			irq_en_q <= '0;
			irq <= 1'b0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
			if (wr_en) begin
				irq_en_q <= hwdata[`IRQ_WIDTH-1:0];
			end
			irq <= |(((irq_stat_q & ~irq_clr) | irq_set) & (wr_en ? hwdata[`IRQ_WIDTH-1:0] : irq_en_q));
		end
	end
endmodule

// ---- verification/framer_asserts.sv ----
// Purpose: port checks of the UTC report framer
// Assumes: one clock, async low reset
// Notes: bound to every framer instance
`timescale 1ns/100ps
module framer_asserts (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire utc_report_pkg::byte_stream_t tx,
	input wire logic tx_ready,
	input wire logic [2:0] followers_go,
	input wire logic irq
);
	import utc_report_pkg::*;
	logic [4:0] pos_q;
	logic [4:0] pos_d;
	wire take = tx.valid & tx_ready;
	// Byte position, so field checks need no look inside
	assign pos_d = !take ? pos_q : (tx.last ? 5'h0 : pos_q + 5'h1);
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			pos_q <= 5'h0;
		else
			pos_q <= pos_d;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	chk_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus not ready or not okay");
	chk_first_subcode: assert property (tx.valid && tx.first |-> tx.data == 8'hAD && pos_q == 0)
		else $error("bad first byte");
	chk_last_fill: assert property (tx.valid && tx.last |-> tx.data == 8'hFF && pos_q == 21)
		else $error("bad last byte");
	chk_byte_held: assert property (tx.valid && !tx_ready |=> $stable(tx))
		else $error("byte changed while stalled");
	chk_follow_last: assert property (followers_go != 0 |-> followers_go == 3 && tx.last)
		else $error("followers out of place");
	chk_follow_pulse: assert property (followers_go != 0 |=> followers_go == 0)
		else $error("followers not a pulse");
	chk_second_range: assert property (tx.valid && pos_q == 13 |-> tx.data <= 8'd60)
		else $error("second out of range");
	chk_flag_reserved: assert property (tx.valid && pos_q == 19 |-> tx.data[3:1] == 0)
		else $error("reserved flag set");
	cover property (take && tx.last);
	cover property (followers_go == 3'd3);
	cover property ($rose(irq));
endmodule
bind utc_time_report_framer framer_asserts framer_asserts_inst (.mclk, .resetn, .hreadyout,
	.hresp, .tx, .tx_ready, .followers_go, .irq);

// ---- verification/report_sink.sv ----
// Purpose: host end of the report stream
// Assumes: byte taken where valid and ready meet
// Notes: stalls one cycle in four
`timescale 1ns/100ps
module report_sink (
	input wire logic mclk,
	input wire logic resetn,
	input wire utc_report_pkg::byte_stream_t tx,
	output logic tx_ready,
	output logic [7:0] rep [0:21],
	output int n_rep
);
	import utc_report_pkg::*;
	logic [1:0] ph_q;
	int idx;
	assign tx_ready = ph_q != 2'h3;
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ph_q <= 2'h0;
			idx <= 0;
			n_rep <= 0;
		end else begin
			ph_q <= ph_q + 2'h1;
			if (tx.valid && tx_ready) begin
				rep[tx.first ? 0 : idx] <= tx.data;
				idx <= tx.first ? 1 : idx + 1;
				if (tx.last)
					n_rep <= n_rep + 1;
			end
		end
	end
endmodule

// ---- verification/test_utc_time_report_framer.sv ----
// Purpose: self-checking bench of the UTC report framer
// Assumes: AHB-Lite master tasks, sink model on the stream
// Notes: leap day and event reports checked byte by byte
`timescale 1ns/100ps
`include "utc_report_defs.svh"
module test_utc_time_report_framer;
	import utc_report_pkg::*;
	logic mclk, resetn, hsel, hwrite, hreadyout, hresp, pps_pin, event_pin, tx_ready, irq;
	logic [1:0] htrans;
	logic [2:0] hsize, followers_go;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [63:0] frac_second;
	byte_stream_t tx;
	logic [7:0] rep [0:21];
	int n_rep, fail_count, n_compared, n_follow;
	logic [39:0] rows [0:8];
	utc_time_report_framer utc_time_report_framer_inst (.mclk, .resetn, .hsel, .haddr,
		.htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
		.pps_pin, .event_pin, .frac_second, .tx, .tx_ready, .followers_go, .irq);
	report_sink report_sink_inst (.mclk, .resetn, .tx, .tx_ready, .rep, .n_rep);
	// Counts release pulses of the synchronous report group
	always @(posedge mclk)
		if (followers_go === `SYNC_FOLLOWERS)
			n_follow <= n_follow + 1;
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'b10;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task pulse(input bit ev);
		if (ev)
			event_pin <= 1'b1;
		else
			pps_pin <= 1'b1;
		repeat (4) @(posedge mclk);
		pps_pin <= 1'b0;
		event_pin <= 1'b0;
	endtask
	task wait_rep(input int n);
		for (int k = 0; k < 500 && n_rep < n; k++) @(posedge mclk);
		chk(n_rep, n);
	endtask
	task chk_rep(input logic [175:0] e);
		for (int i = 0; i < 22; i++) chk(rep[i], e[175-8*i -: 8]);
	endtask
	task conclude;
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	initial begin
		#1_000_000;
		fail_count++;
		conclude;
	end
	initial begin
		{resetn, hsel, hwrite, pps_pin, event_pin, htrans, haddr, hwdata, frac_second} = '0;
		hsize = 3'b010;
		rows = '{40'h00_0000_0003, 40'h04_0000_0003, 40'h08_0000_0000, 40'h0C_07D0_0101,
			40'h10_0000_0000, 40'h14_0000_0000, 40'h18_0000_0000, 40'h20_0000_0000,
			40'h40_0000_0000};
		repeat (6) @(posedge mclk);
		resetn <= 1'b1;
		@(posedge mclk);
		for (int i = 0; i < 9; i++) begin
			ahb(1'b0, rows[i][39:32], 32'h0);
			chk(rd, rows[i][31:0]);
		end
		$display("test reset values done");
		ahb(1'b1, `REG_IRQ_EN, 32'h0000_0001);
		ahb(1'b1, `REG_TIME, 32'h0017_3B3B);
		ahb(1'b1, `REG_DATE, 32'h07DF_061E);
		ahb(1'b1, `REG_CTRL, 32'h0000_003F);
		pulse(1'b0);
		wait_rep(1);
		chk_rep({88'hAD_0000_0000_0000_0000_0000, 56'h17_3B3C_1E06_07DF, 32'h03D1_FFFF});
		repeat (3) @(posedge mclk);
		chk(irq, 1'b1);
		ahb(1'b0, `REG_IRQ_STAT, 32'h0);
		chk(rd, 32'h0000_0003);
		pulse(1'b0);
		wait_rep(2);
		chk_rep({88'hAD_0000_0000_0000_0000_0000, 56'h00_0000_0107_07DF, 32'h0341_FFFF});
		$display("test leap second done");
		ahb(1'b1, `REG_IRQ_CLR, 32'h0000_0007);
		ahb(1'b1, `REG_IRQ_EN, 32'h0);
		ahb(1'b1, `REG_TRACK, 32'h0000_000D);
		frac_second <= 64'h3FE0_0000_0000_0000;
		pulse(1'b1);
		wait_rep(3);
		chk_rep({88'hAD_0001_3FE0_0000_0000_0000, 56'h00_0000_0107_07DF, 32'h0D41_FFFF});
		ahb(1'b0, `REG_EVCNT, 32'h0);
		chk(rd, 32'h0000_0001);
		ahb(1'b0, `REG_IRQ_STAT, 32'h0);
		chk(rd, 32'h0000_0001);
		chk(irq, 1'b0);
		$display("test event report done");
		ahb(1'b1, `REG_CTRL, 32'h0);
		pulse(1'b0);
		repeat (100) @(posedge mclk);
		chk(n_rep, 3);
		$display("test disable done");
		for (int c = 0; c < 14; c++) begin
			ahb(1'b1, `REG_TRACK, c);
			ahb(1'b0, `REG_TRACK, 32'h0);
			chk(rd, c);
		end
		$display("test tracking codes done");
		// Events gated off: no report, counter frozen
		ahb(1'b1, `REG_CTRL, 32'h0000_0001);
		pulse(1'b1);
		repeat (50) @(posedge mclk);
		chk(n_rep, 3);
		ahb(1'b0, `REG_EVCNT, 32'h0);
		chk(rd, 32'h0000_0001);
		$display("test event gate done");
		// PPS report leads; a second event while one waits is an overrun
		ahb(1'b1, `REG_CTRL, 32'h0000_0003);
		ahb(1'b1, `REG_IRQ_CLR, 32'h0000_0007);
		pulse(1'b0);
		@(posedge mclk);
		pulse(1'b1);
		repeat (2) @(posedge mclk);
		pulse(1'b1);
		wait_rep(5);
		chk(rep[2], 8'h02);
		chk(rep[3], 8'h3F);
		chk(n_follow, 3);
		ahb(1'b0, `REG_IRQ_STAT, 32'h0);
		chk(rd, 32'h0000_0005);
		ahb(1'b0, `REG_EVCNT, 32'h0);
		chk(rd, 32'h0000_0003);
		$display("test overrun and order done");
		// Reset in mid-run
		resetn <= 1'b0;
		repeat (2) @(posedge mclk);
		chk(hrdata, 32'h0000_0000);
		chk({tx.valid, irq, followers_go}, 32'h0000_0000);
		resetn <= 1'b1;
		@(posedge mclk);
		ahb(1'b0, `REG_EVCNT, 32'h0);
		chk(rd, 32'h0000_0000);
		ahb(1'b0, `REG_CTRL, 32'h0);
		chk(rd, 32'h0000_0003);
		$display("test mid-run reset done");
		conclude;
	end
endmodule
